// [include/rseq_consts.svh]
`ifndef RSEQ_CONSTS_SVH
`define RSEQ_CONSTS_SVH

`define RSEQ_OFF_CTRL       8'h00
`define RSEQ_OFF_OPER       8'h04
`define RSEQ_OFF_PIN_CTRL   8'h08
`define RSEQ_OFF_OPER_CTRL  8'h0C
`define RSEQ_OFF_RAIL_SEL   8'h10
`define RSEQ_OFF_TON        8'h14
`define RSEQ_OFF_TOFF       8'h18
`define RSEQ_OFF_TMAX_ON    8'h1C
`define RSEQ_OFF_TMAX_OFF   8'h20
`define RSEQ_OFF_PAR_ON     8'h24
`define RSEQ_OFF_PAR_OFF    8'h28
`define RSEQ_OFF_SLAVES     8'h2C
`define RSEQ_OFF_OPT        8'h30
`define RSEQ_OFF_STATE_TBL  8'h40
`define RSEQ_OFF_GOOD       8'h60
`define RSEQ_OFF_STATUS     8'h64
`define RSEQ_OFF_FAULT      8'h68
`define RSEQ_OFF_TON_FLT    8'h6C

`define RSEQ_CTRL_AUTO      0
`define RSEQ_CTRL_PINST     1
`define RSEQ_CTRL_RST       2'h0

`define RSEQ_OPT_MON        0
`define RSEQ_OPT_IMMED      1
`define RSEQ_OPT_GON_EN     2
`define RSEQ_OPT_GON_LVL    3
`define RSEQ_OPT_GON_SEL    4
`define RSEQ_OPT_GOFF_EN    7
`define RSEQ_OPT_GOFF_LVL   8
`define RSEQ_OPT_GOFF_SEL   9
`define RSEQ_OPT_FLT_OFF    12
`define RSEQ_OPT_CASC_IN    13
`define RSEQ_OPT_W          14

`define RSEQ_MAX_DELAY_MS   12'hCCC
`define RSEQ_STATES         8
`define RSEQ_CLK_PERIOD_NS  4
`define RSEQ_MS_NS          1000000
`define RSEQ_SETTLE_NS      1000
`define RSEQ_TICK_CYCLES    (`RSEQ_MS_NS / `RSEQ_CLK_PERIOD_NS)
`define RSEQ_SETTLE_CYCLES  (`RSEQ_SETTLE_NS / `RSEQ_CLK_PERIOD_NS)

`endif

// [include/rseq_pkg.sv]
package rseq_pkg;

  typedef logic [11:0] rseq_ms_t;

  typedef enum logic [5:0] {
    RSEQ_ST_OFF      = 6'h01,
    RSEQ_ST_ON_DLY   = 6'h02,
    RSEQ_ST_RISING   = 6'h04,
    RSEQ_ST_ON       = 6'h08,
    RSEQ_ST_OFF_DLY  = 6'h10,
    RSEQ_ST_FALLING  = 6'h20
  } rseq_rail_e;

endpackage

// [logic/rseq_sync.sv]
`timescale 1ns/10ps
module rseq_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  import rseq_pkg::*;

  logic [W-1:0] meta_reg;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta_reg[g] <= 1'b0;
          d_out[g]    <= 1'b0;
        end else begin
          meta_reg[g] <= d_in[g];
          d_out[g]    <= meta_reg[g];
        end
      end
    end
  endgenerate

endmodule

// [logic/rseq_rail.sv]
`timescale 1ns/10ps
module rseq_rail (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               tick_ms,
  input  wire logic               on_go,
  input  wire logic               off_go,
  input  wire logic               force_off,
  input  wire logic               immediate_off,
  input  wire logic               monitored,
  input  wire logic               pg_above_on,
  input  wire logic               pg_below_off,
  input  wire rseq_pkg::rseq_ms_t turn_on_delay,
  input  wire rseq_pkg::rseq_ms_t turn_off_delay,
  input  wire rseq_pkg::rseq_ms_t tmax_on,
  input  wire rseq_pkg::rseq_ms_t tmax_off,
  output logic                    enable,
  output logic                    good,
  output logic                    ton_timeout
);
  import rseq_pkg::*;

  rseq_rail_e st_reg;
  rseq_rail_e st_next;
  rseq_ms_t   cnt_reg;
  logic       pg_reg;
  logic       stop;

  assign stop = force_off | off_go;
  assign good = monitored ? pg_reg : (st_reg == RSEQ_ST_ON);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      RSEQ_ST_OFF: begin
        if (on_go && !force_off) st_next = RSEQ_ST_ON_DLY;
      end
      RSEQ_ST_ON_DLY: begin
        if (stop) st_next = RSEQ_ST_OFF;
        else if (cnt_reg >= turn_on_delay) st_next = RSEQ_ST_RISING; // RL8
      end
      RSEQ_ST_RISING, RSEQ_ST_ON: begin
        if (stop) st_next = immediate_off ? RSEQ_ST_FALLING : RSEQ_ST_OFF_DLY; // RL12
        else if (st_reg == RSEQ_ST_RISING && (monitored ? pg_reg : cnt_reg >= tmax_on))
          st_next = RSEQ_ST_ON; // RL4 RL5
      end
      RSEQ_ST_OFF_DLY: begin
        if (cnt_reg >= turn_off_delay) st_next = RSEQ_ST_FALLING; // RL10
      end
      RSEQ_ST_FALLING: begin
        if (monitored ? !pg_reg : cnt_reg >= tmax_off) st_next = RSEQ_ST_OFF; // RL6
      end
      default: st_next = RSEQ_ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg      <= RSEQ_ST_OFF;
      cnt_reg     <= 12'h000;
      pg_reg      <= 1'b0;
      enable      <= 1'b0;
      ton_timeout <= 1'b0;
    end else begin
      st_reg  <= st_next;
      // Hysteresis: entry and exit thresholds are separate comparators.
      if (pg_above_on) pg_reg <= 1'b1; // RL4
      else if (pg_below_off) pg_reg <= 1'b0;
      if (st_next != st_reg) cnt_reg <= 12'h000;
      else if (tick_ms && cnt_reg != 12'hFFF) cnt_reg <= cnt_reg + 12'h001;
      enable <= (st_next == RSEQ_ST_RISING) || (st_next == RSEQ_ST_ON) ||
                (st_next == RSEQ_ST_OFF_DLY); // RL1
      // A zero limit never fires, so the rail may keep trying forever.
      ton_timeout <= (st_reg == RSEQ_ST_RISING) && monitored && !pg_reg && tick_ms &&
                     (tmax_on != 12'h000) && (cnt_reg + 12'h001 == tmax_on); // RL11
    end
  end

endmodule

// [logic/rseq_top.sv]
`timescale 1ns/10ps
`include "rseq_consts.svh"
// Contract
// RL1 - One enable output per rail, sixteen rails.
// RL2 - Control pin or operation command starts sequencing.
// RL3 - Auto-enable ignores pin and command entirely.
// RL4 - Monitored rail good between entry and exit thresholds.
// RL5 - Unmonitored rail on after delay plus limit.
// RL6 - Unmonitored rail off after delay plus limit.
// RL7 - Per-rail on triggers: command, pin, parents, input.
// RL8 - Turn-on delay capped at 3276 ms.
// RL9 - Per-rail off triggers including faults and masters.
// RL10 - Turn-off delay capped at 3276 ms.
// RL11 - Max turn-on time in ms, zero unlimited.
// RL12 - Immediate off or sequenced off per rail.
// RL13 - Pin release, soft stop, master fault start off.
// RL14 - Shutdowns cascade to rails and other controllers.
// RL15 - Eight system states hold per-rail on/off settings.
// RL16 - State change obeys rail on/off dependencies.
// RL17 - State change rewrites operation setting only.
// RL18 - Inputs two..zero form binary state code.
// RL19 - Sample state inputs after every reset.
// RL20 - Outside driver settles inputs within one microsecond.
// RL21 - Synchronise pin and inputs before use.
module rseq_top #(
  parameter int RAILS         = 16,
  parameter int GPIS          = 8,
  parameter int TICK_CYCLES   = `RSEQ_TICK_CYCLES,
  parameter int SETTLE_CYCLES = `RSEQ_SETTLE_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sequence_control_pin,
  input  wire logic [GPIS-1:0]  general_input,
  input  wire logic [RAILS-1:0] pg_above_on,
  input  wire logic [RAILS-1:0] pg_below_off,
  input  wire logic [RAILS-1:0] rail_fault,
  input  wire logic             cascade_fault_in,
  output logic      [RAILS-1:0] rail_enable,
  output logic                  cascade_fault_out
);
  import rseq_pkg::*;

  localparam int SYNC_W = GPIS + 2 + 3 * RAILS;
  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int SET_W  = $clog2(SETTLE_CYCLES + 1);

  generate
    if (RAILS < 1 || RAILS > 16 || GPIS < 3 || GPIS > 8 ||
        TICK_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_bad_param
      $error("rseq_top: parameter out of supported range");
    end
  endgenerate

  function automatic rseq_ms_t clamp_delay(input logic [31:0] d);
    clamp_delay = (d > 32'h0000_0CCC) ? `RSEQ_MAX_DELAY_MS : d[11:0];
  endfunction

  function automatic logic gpi_match(input logic [GPIS-1:0] gi,
                                     input logic [2:0]      sel,
                                     input logic            lvl);
    gpi_match = (32'(sel) < GPIS) ? (gi[sel] == lvl) : 1'b0;
  endfunction

  // Input synchronisers.
  logic [SYNC_W-1:0] sync_out;
  logic [GPIS-1:0]   gi_s;
  logic              pin_s;
  logic              casc_s;
  logic [RAILS-1:0]  pgon_s;
  logic [RAILS-1:0]  pgoff_s;
  logic [RAILS-1:0]  flt_s;

  rseq_sync #(
    .W (SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d_in    ({general_input, sequence_control_pin, cascade_fault_in,
               pg_above_on, pg_below_off, rail_fault}),
    .d_out   (sync_out)
  ); // RL21

  assign {gi_s, pin_s, casc_s, pgon_s, pgoff_s, flt_s} = sync_out;

  // Millisecond tick divider.
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (32'(tick_cnt_reg) == TICK_CYCLES - 1);
      tick_cnt_reg <= (32'(tick_cnt_reg) == TICK_CYCLES - 1) ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // Register storage.
  logic [1:0]              ctrl_reg;
  logic [RAILS-1:0]        oper_reg;
  logic [RAILS-1:0]        oper_next;
  logic [RAILS-1:0]        pin_ctrl_reg;
  logic [RAILS-1:0]        oper_ctrl_reg;
  logic [3:0]              sel_reg;
  rseq_ms_t                ton_reg      [RAILS];
  rseq_ms_t                toff_reg     [RAILS];
  rseq_ms_t                tmon_reg     [RAILS];
  rseq_ms_t                tmoff_reg    [RAILS];
  logic [RAILS-1:0]        par_on_reg   [RAILS];
  logic [RAILS-1:0]        par_off_reg  [RAILS];
  logic [RAILS-1:0]        slave_reg    [RAILS];
  logic [`RSEQ_OPT_W-1:0]  opt_reg      [RAILS];
  logic [RAILS-1:0]        tbl_reg      [`RSEQ_STATES];
  logic [RAILS-1:0]        fault_reg;
  logic [RAILS-1:0]        ton_flt_reg;

  // APB decode.
  logic        setup;
  logic        wr_en;
  logic        tbl_hit;
  logic        addr_hit;
  logic [2:0]  tbl_idx;
  logic [3:0]  sel;
  logic [31:0] rd_data;

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
  assign tbl_hit  = (paddr[7:5] == 3'h2) && (paddr[1:0] == 2'h0);
  assign tbl_idx  = paddr[4:2];
  assign sel      = (32'(sel_reg) < RAILS) ? sel_reg : 4'h0;
  assign addr_hit = tbl_hit || (paddr inside {`RSEQ_OFF_CTRL, `RSEQ_OFF_OPER,
                    `RSEQ_OFF_PIN_CTRL, `RSEQ_OFF_OPER_CTRL, `RSEQ_OFF_RAIL_SEL,
                    `RSEQ_OFF_TON, `RSEQ_OFF_TOFF, `RSEQ_OFF_TMAX_ON, `RSEQ_OFF_TMAX_OFF,
                    `RSEQ_OFF_PAR_ON, `RSEQ_OFF_PAR_OFF, `RSEQ_OFF_SLAVES, `RSEQ_OFF_OPT,
                    `RSEQ_OFF_GOOD, `RSEQ_OFF_STATUS, `RSEQ_OFF_FAULT, `RSEQ_OFF_TON_FLT});

  logic [RAILS-1:0] good;
  logic [2:0]       st_applied_reg;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      `RSEQ_OFF_CTRL:      rd_data = 32'(ctrl_reg);
      `RSEQ_OFF_OPER:      rd_data = 32'(oper_reg);
      `RSEQ_OFF_PIN_CTRL:  rd_data = 32'(pin_ctrl_reg);
      `RSEQ_OFF_OPER_CTRL: rd_data = 32'(oper_ctrl_reg);
      `RSEQ_OFF_RAIL_SEL:  rd_data = 32'(sel_reg);
      `RSEQ_OFF_TON:       rd_data = 32'(ton_reg[sel]);
      `RSEQ_OFF_TOFF:      rd_data = 32'(toff_reg[sel]);
      `RSEQ_OFF_TMAX_ON:   rd_data = 32'(tmon_reg[sel]);
      `RSEQ_OFF_TMAX_OFF:  rd_data = 32'(tmoff_reg[sel]);
      `RSEQ_OFF_PAR_ON:    rd_data = 32'(par_on_reg[sel]);
      `RSEQ_OFF_PAR_OFF:   rd_data = 32'(par_off_reg[sel]);
      `RSEQ_OFF_SLAVES:    rd_data = 32'(slave_reg[sel]);
      `RSEQ_OFF_OPT:       rd_data = 32'(opt_reg[sel]);
      `RSEQ_OFF_GOOD:      rd_data = 32'(good);
      `RSEQ_OFF_STATUS:    rd_data = {5'h00, st_applied_reg, 8'h00, 16'(rail_enable)};
      `RSEQ_OFF_FAULT:     rd_data = 32'(fault_reg);
      `RSEQ_OFF_TON_FLT:   rd_data = 32'(ton_flt_reg);
      default: begin
        if (tbl_hit) rd_data = 32'(tbl_reg[tbl_idx]);
      end
    endcase
  end

  // The answer is registered in the setup cycle, so every access has
  // exactly one access-phase cycle and no wait states.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_hit;
      prdata  <= (setup & ~pwrite & addr_hit) ? rd_data : 32'h0000_0000;
    end
  end

  // Configuration writes.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg      <= `RSEQ_CTRL_RST;
      pin_ctrl_reg  <= '0;
      oper_ctrl_reg <= '0;
      sel_reg       <= 4'h0;
      for (int i = 0; i < RAILS; i++) begin
        ton_reg[i]     <= 12'h000;
        toff_reg[i]    <= 12'h000;
        tmon_reg[i]    <= 12'h000;
        tmoff_reg[i]   <= 12'h000;
        par_on_reg[i]  <= '0;
        par_off_reg[i] <= '0;
        slave_reg[i]   <= '0;
        opt_reg[i]     <= '0;
      end
      for (int s = 0; s < `RSEQ_STATES; s++) tbl_reg[s] <= '0;
    end else if (wr_en) begin
      case (paddr)
        `RSEQ_OFF_CTRL:      ctrl_reg           <= pwdata[1:0];
        `RSEQ_OFF_PIN_CTRL:  pin_ctrl_reg       <= pwdata[RAILS-1:0];
        `RSEQ_OFF_OPER_CTRL: oper_ctrl_reg      <= pwdata[RAILS-1:0];
        `RSEQ_OFF_RAIL_SEL:  sel_reg            <= pwdata[3:0];
        `RSEQ_OFF_TON:       ton_reg[sel]       <= clamp_delay(pwdata); // RL8
        `RSEQ_OFF_TOFF:      toff_reg[sel]      <= clamp_delay(pwdata); // RL10
        `RSEQ_OFF_TMAX_ON:   tmon_reg[sel]      <= pwdata[11:0]; // RL11
        `RSEQ_OFF_TMAX_OFF:  tmoff_reg[sel]     <= pwdata[11:0];
        `RSEQ_OFF_PAR_ON:    par_on_reg[sel]    <= pwdata[RAILS-1:0];
        `RSEQ_OFF_PAR_OFF:   par_off_reg[sel]   <= pwdata[RAILS-1:0];
        `RSEQ_OFF_SLAVES:    slave_reg[sel]     <= pwdata[RAILS-1:0];
        `RSEQ_OFF_OPT:       opt_reg[sel]       <= pwdata[`RSEQ_OPT_W-1:0];
        default: begin
          if (tbl_hit) tbl_reg[tbl_idx] <= pwdata[RAILS-1:0]; // RL15
        end
      endcase
    end
  end

  // System state selection from the first three general inputs.
  logic [2:0]       st_code;
  logic [2:0]       st_last_reg;
  logic [SET_W-1:0] settle_reg;
  logic             init_pend_reg;
  logic             settled;
  logic             st_apply;

  assign st_code  = gi_s[2:0]; // RL18
  assign settled  = (32'(settle_reg) == SETTLE_CYCLES);
  // Waiting out the settle window keeps a slewing input code from
  // passing through an intermediate state.
  assign st_apply = settled && ctrl_reg[`RSEQ_CTRL_PINST] &&
                    (init_pend_reg || (st_last_reg != st_applied_reg)); // RL20

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_last_reg    <= 3'h0;
      st_applied_reg <= 3'h0;
      settle_reg     <= '0;
      init_pend_reg  <= 1'b1;
    end else begin
      st_last_reg <= st_code;
      if (st_code != st_last_reg) settle_reg <= '0;
      else if (!settled) settle_reg <= settle_reg + 1'b1;
      if (st_apply) st_applied_reg <= st_last_reg;
      // The code sampled after reset stays pending until the feature is
      // enabled, so even state zero is applied once.
      if (st_apply) init_pend_reg <= 1'b0; // RL19
    end
  end

  // Operation setting: software writes it, a state change rewrites only the
  // rails that follow the operation command.
  always_comb begin
    oper_next = oper_reg;
    if (wr_en && paddr == `RSEQ_OFF_OPER) oper_next = pwdata[RAILS-1:0];
    if (st_apply)
      oper_next = (oper_next & ~oper_ctrl_reg) | (tbl_reg[st_last_reg] & oper_ctrl_reg); // RL17
  end

  always_ff @(posedge sys_clk) begin
    if (rst) oper_reg <= '0;
    else oper_reg <= oper_next;
  end

  // Fault shutdown and cascading.
  logic [RAILS-1:0] ton_to;
  logic [RAILS-1:0] fault_ev;
  logic [RAILS-1:0] fault_set;
  logic [RAILS-1:0] has_slaves;
  logic [RAILS-1:0] want_on;
  logic [RAILS-1:0] on_go;
  logic [RAILS-1:0] off_go;
  logic             fault_clr;
  logic             tonf_clr;

  assign fault_ev  = flt_s | ton_to;
  assign fault_clr = wr_en && (paddr == `RSEQ_OFF_FAULT);
  assign tonf_clr  = wr_en && (paddr == `RSEQ_OFF_TON_FLT);

  genvar r;
  generate
    for (r = 0; r < RAILS; r++) begin : g_rail
      logic [RAILS-1:0] masters;
      logic             base_on;
      logic             on_deps;
      logic             off_deps;

      for (genvar m = 0; m < RAILS; m++) begin : g_master
        assign masters[m] = slave_reg[m][r] & fault_ev[m];
      end

      assign has_slaves[r] = |slave_reg[r];
      assign fault_set[r]  = (fault_ev[r] & opt_reg[r][`RSEQ_OPT_FLT_OFF]) | (|masters) |
                             (casc_s & opt_reg[r][`RSEQ_OPT_CASC_IN]); // RL9 RL13 RL14
      assign base_on       = ctrl_reg[`RSEQ_CTRL_AUTO] ? 1'b1 :
                             ((pin_ctrl_reg[r] & pin_s) | (oper_ctrl_reg[r] & oper_reg[r])); // RL2 RL3
      assign want_on[r]    = base_on & ~fault_reg[r];
      assign on_deps       = (&(~par_on_reg[r] | good)) &&
                             (!opt_reg[r][`RSEQ_OPT_GON_EN] ||
                              gpi_match(gi_s, opt_reg[r][`RSEQ_OPT_GON_SEL +: 3],
                                        opt_reg[r][`RSEQ_OPT_GON_LVL])); // RL7 RL16
      assign off_deps      = (~|(par_off_reg[r] & good)) &&
                             (!opt_reg[r][`RSEQ_OPT_GOFF_EN] ||
                              gpi_match(gi_s, opt_reg[r][`RSEQ_OPT_GOFF_SEL +: 3],
                                        opt_reg[r][`RSEQ_OPT_GOFF_LVL])); // RL9 RL16
      assign on_go[r]      = want_on[r] & on_deps;
      assign off_go[r]     = ~base_on & off_deps;

      rseq_rail u_rail (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .tick_ms       (tick_reg),
        .on_go         (on_go[r]),
        .off_go        (off_go[r]),
        .force_off     (fault_reg[r]),
        .immediate_off (opt_reg[r][`RSEQ_OPT_IMMED]),
        .monitored     (opt_reg[r][`RSEQ_OPT_MON]),
        .pg_above_on   (pgon_s[r]),
        .pg_below_off  (pgoff_s[r]),
        .turn_on_delay     (ton_reg[r]),
        .turn_off_delay    (toff_reg[r]),
        .tmax_on       (tmon_reg[r]),
        .tmax_off      (tmoff_reg[r]),
        .enable        (rail_enable[r]),
        .good          (good[r]),
        .ton_timeout   (ton_to[r])
      ); // RL1
    end
  endgenerate

  // Sticky flags: a new event in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_reg         <= '0;
      ton_flt_reg       <= '0;
      cascade_fault_out <= 1'b0;
    end else begin
      fault_reg   <= (fault_reg & ~(fault_clr ? pwdata[RAILS-1:0] : '0)) | fault_set;
      ton_flt_reg <= (ton_flt_reg & ~(tonf_clr ? pwdata[RAILS-1:0] : '0)) | ton_to;
      cascade_fault_out <= |(fault_ev & has_slaves) | (|fault_reg); // RL14
    end
  end

endmodule

// [verification/rseq_top_monitor.sv]
`timescale 1ns/10ps
module rseq_top_monitor #(
  parameter int RAILS = 16
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [RAILS-1:0] rail_enable,
  input wire logic             cascade_fault_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire setup = psel && !penable;
  chk_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_misalign_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  chk_hole_err: assert property (setup && paddr == 8'h34 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (setup && paddr == 8'h00 |=> pready && !pslverr)
    else $error("mapped access refused");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_reset_off: assert property (disable iff (1'b0)
    rst |=> rail_enable == '0 && !cascade_fault_out)
    else $error("outputs not cleared by reset");
  cover property ($rose(rail_enable[0]));
  cover property (pslverr);
  cover property ($rose(cascade_fault_out));
endmodule

bind rseq_top rseq_top_monitor #(.RAILS(RAILS)) u_mon (.sys_clk(sys_clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rail_enable(rail_enable), .cascade_fault_out(cascade_fault_out));

// [verification/rseq_supply_model.sv]
`timescale 1ns/10ps
module rseq_supply_model #(
  parameter int RAILS = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [RAILS-1:0] rail_enable,
  output logic      [RAILS-1:0] pg_above_on,
  output logic      [RAILS-1:0] pg_below_off
);
  // A ramp makes power-good lag the enable, so a sequencer that skips the wait is caught.
  logic [4:0] lvl_reg [RAILS];
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < RAILS; i++) begin
      if (rst) lvl_reg[i] <= 5'h00;
      else if (rail_enable[i] && lvl_reg[i] != 5'h1F) lvl_reg[i] <= lvl_reg[i] + 5'h01;
      else if (!rail_enable[i] && lvl_reg[i] != 5'h00) lvl_reg[i] <= lvl_reg[i] - 5'h01;
    end
  end
  always_comb begin
    for (int i = 0; i < RAILS; i++) begin
      pg_above_on[i]  = lvl_reg[i] > 5'h18;
      pg_below_off[i] = lvl_reg[i] < 5'h06;
    end
  end
endmodule

// [verification/rseq_top_tb.sv]
`timescale 1ns/10ps
`include "rseq_consts.svh"
module rseq_top_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin = 1'b0;
  logic [7:0]  gi = 8'h00;
  logic [15:0] pg_on;
  logic [15:0] pg_off;
  logic [15:0] flt = 16'h0000;
  logic [15:0] en;
  logic        casc;
  logic        casc_in = 1'b0;
  int          err_total = 0;
  int          compares = 0;
  rseq_top #(.TICK_CYCLES(10), .SETTLE_CYCLES(4)) uut (.sys_clk(sys_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sequence_control_pin(pin),
    .general_input(gi), .pg_above_on(pg_on), .pg_below_off(pg_off), .rail_fault(flt),
    .cascade_fault_in(casc_in), .rail_enable(en), .cascade_fault_out(casc));
  rseq_supply_model u_sup (.sys_clk(sys_clk), .rst(rst), .rail_enable(en),
    .pg_above_on(pg_on), .pg_below_off(pg_off));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wen(input int i, input logic v, input int n);
    while (n > 0 && en[i] !== v) begin cyc(1); n--; end
    chk({31'h0, en[i]}, {31'h0, v});
  endtask
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    chk({16'h0, en}, 32'h0);
    apb(8'h01, 1'b1, 32'h3, q, e);
    chk({31'h0, e}, 32'h1);
    rd(`RSEQ_OFF_CTRL, 32'h0);
    apb(8'h34, 1'b0, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(`RSEQ_OFF_TON, 32'hFFF);
    rd(`RSEQ_OFF_TON, 32'hCCC);
    wr(`RSEQ_OFF_TOFF, 32'hFFF);
    rd(`RSEQ_OFF_TOFF, 32'hCCC);
    $display("reset and clamp done");
  endtask
  task automatic t_pin;
    wr(`RSEQ_OFF_TON, 32'h3);
    wr(`RSEQ_OFF_TOFF, 32'h2);
    wr(`RSEQ_OFF_PIN_CTRL, 32'h1);
    pin <= 1'b1;
    cyc(20);
    chk({31'h0, en[0]}, 32'h0);
    wen(0, 1'b1, 40);
    pin <= 1'b0;
    cyc(10);
    chk({31'h0, en[0]}, 32'h1);
    wen(0, 1'b0, 40);
    $display("pin sequencing done");
  endtask
  task automatic t_parent;
    wr(`RSEQ_OFF_RAIL_SEL, 32'h1);
    wr(`RSEQ_OFF_OPT, 32'h1003);
    wr(`RSEQ_OFF_RAIL_SEL, 32'h3);
    wr(`RSEQ_OFF_PAR_ON, 32'h2);
    wr(`RSEQ_OFF_OPT, 32'h2);
    wr(`RSEQ_OFF_OPER_CTRL, 32'hA);
    wr(`RSEQ_OFF_OPER, 32'hA);
    wen(1, 1'b1, 20);
    chk({31'h0, en[3]}, 32'h0);
    wen(3, 1'b1, 80);
    rd(`RSEQ_OFF_GOOD, 32'hA);
    wr(`RSEQ_OFF_OPER, 32'h2);
    wen(3, 1'b0, 8);
    flt <= 16'h0002;
    wen(1, 1'b0, 20);
    chk({31'h0, casc}, 32'h1);
    rd(`RSEQ_OFF_FAULT, 32'h2);
    flt <= 16'h0000;
    wr(`RSEQ_OFF_FAULT, 32'h2);
    rd(`RSEQ_OFF_FAULT, 32'h0);
    $display("parent and fault done");
  endtask
  task automatic t_state;
    logic [31:0] v;
    for (int s = 0; s < 8; s++) begin
      v = {28'h0, s[2], 1'b0, s[0], s[1]};
      wr(`RSEQ_OFF_STATE_TBL + 8'(4 * s), v);
    end
    wr(`RSEQ_OFF_CTRL, 32'h2);
    for (int i = 1; i <= 8; i++) begin
      gi <= 8'(i % 8);
      cyc(30);
      rd(`RSEQ_OFF_OPER, {28'h0, i[2], 1'b0, i[0], 1'b0});
    end
    wr(`RSEQ_OFF_CTRL, 32'h1);
    wen(0, 1'b1, 60);
    $display("states and auto done");
  endtask
  task automatic t_boot;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    chk({16'h0, en}, 32'h0);
    wr(`RSEQ_OFF_RAIL_SEL, 32'h1);
    wr(`RSEQ_OFF_TMAX_ON, 32'h1);
    wr(`RSEQ_OFF_OPT, 32'h1);
    wr(`RSEQ_OFF_RAIL_SEL, 32'h2);
    wr(`RSEQ_OFF_OPT, 32'h2002);
    wr(`RSEQ_OFF_STATE_TBL, 32'h6);
    wr(`RSEQ_OFF_OPER, 32'hE);
    wr(`RSEQ_OFF_OPER_CTRL, 32'hE);
    wr(`RSEQ_OFF_CTRL, 32'h2);
    rd(`RSEQ_OFF_OPER, 32'h6);
    wen(3, 1'b0, 20);
    wen(2, 1'b1, 20);
    wr(`RSEQ_OFF_RAIL_SEL, 32'h0);
    wr(`RSEQ_OFF_SLAVES, 32'h4);
    flt <= 16'h0001;
    wen(2, 1'b0, 20);
    chk({31'h0, casc}, 32'h1);
    flt <= 16'h0000;
    wr(`RSEQ_OFF_FAULT, 32'h4);
    wen(2, 1'b1, 20);
    casc_in <= 1'b1;
    wen(2, 1'b0, 20);
    rd(`RSEQ_OFF_FAULT, 32'h4);
    rd(`RSEQ_OFF_TON_FLT, 32'h2);
    $display("reset states and cascade done");
  endtask
  task automatic conclude;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_pin();
    t_parent();
    t_state();
    t_boot();
    conclude();
  end
  initial begin
    #80000;
    err_total++;
    conclude();
  end
endmodule
